// ===== rtl/lwn_params.svh
// Constants for the link-on wake notification block
`ifndef LWN_PARAMS_SVH
`define LWN_PARAMS_SVH
`define LWN_CLK_PERIOD_NS 50
`define LWN_SQ_PERIOD_CYC 8
`define LWN_SQ_HALF_CYC 4
`define LWN_PWR_TIMEOUT_MS 167
`define LWN_PWR_TIMEOUT_CYC ((`LWN_PWR_TIMEOUT_MS * 1000000) / `LWN_CLK_PERIOD_NS)
`define LWN_PCLASS_MAX 3'h4
`define LWN_PMCSR_OFFSET 8'h48
`define LWN_PM_EVENT_STATUS_BIT 15
`define LWN_CNT_W 32
`endif

// ===== rtl/lwn_pkg.sv
// Types shared by the link-on wake notification block
`default_nettype none
package lwn_pkg;
	// Qualifying interrupt bits from the physical-layer register file
	typedef struct packed {
		logic portEventIrq;
		logic configTimeoutIrq;
		logic cablePowerIrq;
		logic stateTimeoutIrq;
		logic resumePortIrqEnable;
	} lwn_irq_t;
	// Link layer power status as seen by the physical layer
	typedef struct packed {
		logic linkPowerState;
		logic linkControlBit;
	} lwn_link_t;
	// Link power states of the link-layer section
	typedef enum logic [1:0] {
		LWN_PS_D0_UNINIT,
		LWN_PS_D0_ACTIVE,
		LWN_PS_D2,
		LWN_PS_D3
	} lwn_pstate_t;
	// Output driver states
	typedef enum {LWN_IDLE, LWN_WAKE} lwn_state_t;
endpackage
`default_nettype wire

// ===== rtl/lwn_square_gen.sv
// Square-wave generator, half period of a given number of clocks
`default_nettype none
`include "lwn_params.svh"
module lwn_square_gen #(
	parameter int HALF = `LWN_SQ_HALF_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic enable,
	output logic wave
);
	localparam int CW = $clog2(HALF) + 1;
	logic [CW-1:0] cnt_reg; // Cycles within a half period
	logic [CW-1:0] cnt_next;
	logic wave_reg; // Square wave level
	logic wave_next;
	// Count half periods; restart low whenever disabled
	always_comb begin
		cnt_next = cnt_reg;
		wave_next = wave_reg;
		if (!enable) begin
			cnt_next = '0;
			wave_next = 1'b0;
		end else if (cnt_reg == CW'(HALF - 1)) begin
			cnt_next = '0;
			wave_next = ~wave_reg;
		end else begin
			cnt_next = cnt_reg + CW'(1);
		end
	end
	// Register stage
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			wave_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			wave_reg <= wave_next;
		end
	end
	assign wave = wave_reg;
endmodule
`default_nettype wire

// ===== rtl/lwn_pme_flag.sv
// Link-side wake capture into the power-management event status flag
`default_nettype none
`include "lwn_params.svh"
module lwn_pme_flag (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic wakeNotifyIn,
	input wire lwn_pkg::lwn_pstate_t pState,
	input wire logic pmeStsClear,
	output logic pmEventStatus
);
	import lwn_pkg::*;
	logic seen_reg; // Previous wake input, for rising edge
	logic seen_next;
	logic sts_reg; // Sticky event flag
	logic sts_next;
	logic listen; // Input only counts while the link power state is not D0 active
	// Set beats clear so a wake in the clear cycle is kept
	always_comb begin
		listen = (pState != LWN_PS_D0_ACTIVE);
		seen_next = wakeNotifyIn;
		sts_next = sts_reg;
		if (pmeStsClear) begin
			sts_next = 1'b0;
		end
		if (listen && wakeNotifyIn && !seen_reg) begin
			sts_next = 1'b1;
		end
	end
	// Register stage
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			seen_reg <= 1'b0;
			sts_reg <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			sts_reg <= sts_next;
		end
	end
	assign pmEventStatus = sts_reg;
endmodule
`default_nettype wire

// ===== rtl/lwn_wake_notify.sv
// Link-on wake notification: physical-layer driver and link-layer capture
`default_nettype none
`include "lwn_params.svh"
module lwn_wake_notify #(
	parameter int PWR_TIMEOUT_CYC = `LWN_PWR_TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire lwn_pkg::lwn_link_t linkStatus,
	input wire lwn_pkg::lwn_irq_t irqBits,
	input wire logic linkOnPacket,
	input wire logic busReset,
	input wire logic powerCycled,
	input wire logic [2:0] powerClass,
	input wire logic wakeNotifyIn,
	input wire lwn_pkg::lwn_pstate_t pState,
	input wire logic pmeStsClear,
	input wire logic linkRequestIn,
	input wire logic phyStatusIn,
	output logic wakeNotifyOut,
	output logic wakeNotifyOe,
	output logic pmEventStatus,
	output logic linkRequestOut,
	output logic phySerialStatus
);
	import lwn_pkg::*;
	lwn_state_t state_reg; // Driver state
	lwn_state_t state_next;
	logic pkt_reg; // Packet cause latched
	logic pkt_next;
	logic pwr_reg; // Power-cycle cause latched
	logic pwr_next;
	logic [`LWN_CNT_W-1:0] tmo_reg; // Power-cycle timeout counter
	logic [`LWN_CNT_W-1:0] tmo_next;
	logic req_reg; // Registered serial request out
	logic stat_reg; // Registered serial status out
	logic linkActive; // Link layer fully up
	logic irqCause; // Level interrupt cause present
	logic anyCause; // Some cause still holds
	logic wave; // Square wave from generator

	// Decode causes from the current inputs and the latched causes
	always_comb begin
		linkActive = linkStatus.linkPowerState && linkStatus.linkControlBit;
		irqCause = irqBits.portEventIrq;
		if (irqBits.resumePortIrqEnable && (irqBits.configTimeoutIrq ||
			irqBits.cablePowerIrq || irqBits.stateTimeoutIrq)) begin
			irqCause = 1'b1;
		end
		anyCause = irqCause || pkt_reg || pwr_reg;
	end

	// Cause latches and driver state
	always_comb begin
		pkt_next = pkt_reg;
		pwr_next = pwr_reg;
		tmo_next = tmo_reg;
		state_next = state_reg;
		// Latches are only armed while the link is down
		if (!linkActive && linkOnPacket) begin
			pkt_next = 1'b1;
		end
		if (!linkActive && powerCycled && powerClass <= `LWN_PCLASS_MAX) begin
			pwr_next = 1'b1;
			tmo_next = '0;
		end
		if (busReset) begin
			pkt_next = 1'b0;
		end
		if (pwr_reg) begin
			if (tmo_reg >= `LWN_CNT_W'(PWR_TIMEOUT_CYC - 1)) begin
				pwr_next = 1'b0;
			end else begin
				tmo_next = tmo_reg + `LWN_CNT_W'(1);
			end
		end
		if (linkActive) begin
			// Link is up: latched causes served, only levels survive
			pkt_next = 1'b0;
			pwr_next = 1'b0;
			tmo_next = '0;
		end
		unique case (state_reg)
			LWN_IDLE: begin
				// Interrupt level left over from an active link starts us here
				if (!linkActive && (irqCause || pkt_next || pwr_next)) begin
					state_next = LWN_WAKE;
				end
			end
			LWN_WAKE: begin
				if (linkActive) begin
					state_next = LWN_IDLE;
				end else if (!irqCause && !pkt_next && !pwr_next) begin
					state_next = LWN_IDLE;
				end
			end
		endcase
	end

	// Register stage for the driver
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= LWN_IDLE;
			pkt_reg <= 1'b0;
			pwr_reg <= 1'b0;
			tmo_reg <= '0;
			req_reg <= 1'b0;
			stat_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pkt_reg <= pkt_next;
			pwr_reg <= pwr_next;
			tmo_reg <= tmo_next;
			req_reg <= linkRequestIn;
			stat_reg <= phyStatusIn;
		end
	end

	// Square wave only runs in the wake state
	lwn_square_gen #(
		.HALF(`LWN_SQ_HALF_CYC)
	) u_square (
		.clock(clock),
		.sys_rst(sys_rst),
		.enable(state_reg == LWN_WAKE),
		.wave(wave)
	);

	// Output released during reset, otherwise driven (low from the second idle cycle on)
	assign wakeNotifyOut = wave;
	assign wakeNotifyOe = !sys_rst;

	// Link-layer capture of the wake input
	lwn_pme_flag u_pme (
		.clock(clock),
		.sys_rst(sys_rst),
		.wakeNotifyIn(wakeNotifyIn),
		.pState(pState),
		.pmeStsClear(pmeStsClear),
		.pmEventStatus(pmEventStatus)
	);

	// Serial lines are passed through one register, no protocol decoding here
	assign linkRequestOut = req_reg;
	assign phySerialStatus = stat_reg;
endmodule
`default_nettype wire

// ===== tb/lwn_wake_notify_chk.sv
// Port assertions for the link-on wake notification block
`default_nettype none
module lwn_wake_notify_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire lwn_pkg::lwn_link_t linkStatus,
	input wire lwn_pkg::lwn_irq_t irqBits,
	input wire logic linkOnPacket,
	input wire logic busReset,
	input wire logic wakeNotifyIn,
	input wire lwn_pkg::lwn_pstate_t pState,
	input wire logic wakeNotifyOut,
	input wire logic wakeNotifyOe,
	input wire logic pmEventStatus
);
	import lwn_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Link fully up, and the wave itself
	wire logic up = &linkStatus;
	wire logic o = wakeNotifyOut;
	// A running wave always differs from itself half a period back
	property p_oe; wakeNotifyOe; endproperty
	a_oe: assert property (p_oe) else $error("pin released");
	property p_hi; $rose(o) |-> ##4 !o; endproperty
	a_hi: assert property (p_hi) else $error("high phase");
	property p_lo; $fell(o) |=> !o[*3]; endproperty
	a_lo: assert property (p_lo) else $error("low phase");
	property p_act; up[*3] |-> !o; endproperty
	a_act: assert property (p_act) else $error("wave while up");
	property p_pkt; linkOnPacket && !up && !busReset ##1 (!up && !busReset)[*5]
		|-> o != $past(o, 4); endproperty
	a_pkt: assert property (p_pkt) else $error("packet wake");
	property p_pei; (irqBits.portEventIrq && !up)[*6] |-> o != $past(o, 4); endproperty
	a_pei: assert property (p_pei) else $error("port event wake");
	property p_grp; (irqBits.resumePortIrqEnable && |irqBits[3:1] && !up)[*6]
		|-> o != $past(o, 4); endproperty
	a_grp: assert property (p_grp) else $error("enabled irq wake");
	property p_pme; $rose(wakeNotifyIn) && pState != LWN_PS_D0_ACTIVE |=> pmEventStatus;
	endproperty
	a_pme: assert property (p_pme) else $error("flag not set");
	property p_pst; $rose(pmEventStatus) |-> $past(pState) != LWN_PS_D0_ACTIVE; endproperty
	a_pst: assert property (p_pst) else $error("flag while up");
endmodule
bind lwn_wake_notify lwn_wake_notify_chk chk (.clock(clock), .sys_rst(sys_rst),
	.linkStatus(linkStatus), .irqBits(irqBits), .linkOnPacket(linkOnPacket),
	.busReset(busReset), .wakeNotifyIn(wakeNotifyIn), .pState(pState),
	.wakeNotifyOut(wakeNotifyOut), .wakeNotifyOe(wakeNotifyOe), .pmEventStatus(pmEventStatus));
`default_nettype wire

// ===== tb/lwn_link_model.sv
// Link-layer side model: power state, control bit and the wake line
`default_nettype none
module lwn_link_model (
	input wire logic clock,
	input wire logic wakeOut,
	input wire logic wakeOe,
	input wire logic [1:0] mode,
	output lwn_pkg::lwn_link_t linkStatus,
	output lwn_pkg::lwn_pstate_t pState,
	output logic wakeIn
);
	import lwn_pkg::*;
	// Pull-up holds the line high while the driver is released
	assign wakeIn = wakeOe ? wakeOut : 1'b1;
	// Mode 3 up; 2 uninitialised; 1 D2; 0 D3; answers a cycle late
	always_ff @(posedge clock) begin
		linkStatus <= lwn_link_t'(mode);
		pState <= mode == 2'h3 ? LWN_PS_D0_ACTIVE :
			mode == 2'h2 ? LWN_PS_D0_UNINIT : lwn_pstate_t'(~mode);
	end
endmodule
`default_nettype wire

// ===== tb/test_lwn_wake_notify.sv
// Self-checking bench for the link-on wake notification block
`default_nettype none
module test_lwn_wake_notify;
	timeunit 1ns;
	timeprecision 1ns;
	import lwn_pkg::*;
	localparam int TO = 50; // Short power-cycle timeout
	logic clock = 0, sys_rst = 1, pkt = 0, busRst = 0, pwrCyc = 0, clr = 0, rq = 0, ps = 0;
	logic [2:0] pwrClass = 3'h0;
	logic [1:0] mode = 2'h0;
	lwn_irq_t irq = '0;
	lwn_link_t ls;
	lwn_pstate_t pst;
	logic wIn, wOut, wOe, pme, rqOut, psOut, hi, armed = 0;
	int seed = 24, mismatches = 0, samples_checked = 0;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Runs n cycles, noting whether the wave went high
	task automatic run(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge clock);
			#5 hi |= wOut;
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		run(1);
		s = 0;
	endtask
	function automatic logic irqWake(lwn_irq_t b);
		return b.portEventIrq | (b.resumePortIrqEnable & |b[3:1]);
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial forever #25 clock = ~clock;
	// Serial bits change every cycle and must come back one cycle later
	// Compare just after the edge, before the next bit replaces the old one
	always @(posedge clock) begin
		armed <= !sys_rst;
		#1 if (armed) chk({rqOut, psOut}, {rq, ps});
		#4 {rq, ps} = 2'($random(seed));
	end
	initial begin
		#250000 mismatches++;
		give_verdict;
	end
	initial begin
		run(4);
		chk(wOe, 0);
		sys_rst = 0;
		run(2);
		chk({wOe, wOut}, 2'h2);
		pulse(pkt);
		run(3);
		chk(hi, 0);
		run(1);
		chk(hi, 1);
		for (int i = 0; i < 8; i++) begin
			run(1);
			chk(wOut, i < 3 || i == 7);
		end
		chk(pme, 1);
		pulse(busRst);
		run(12);
		chk(hi, 0);
		// Corner codes first, then random interrupt sets
		for (int i = 0; i < 14; i++) begin
			// Later corner codes carry the resume enable bit as well
			irq = i < 5 ? (5'h10 >> (i & 1) * 2 + i / 3) | 5'(i > 2) : 5'($random(seed));
			mode = 2'h3;
			run(10);
			chk(hi, 0);
			pulse(clr);
			mode = 2'(i % 3);
			pulse(busRst);
			run(12);
			chk(hi, irqWake(irq));
			chk(pme, irqWake(irq));
			irq = '0;
			// Let a running wave wind down before the link comes up again
			run(2);
		end
		mode = 2'h0;
		run(4);
		for (int c = 0; c < 8; c++) begin
			pwrClass = 3'(c);
			pulse(pwrCyc);
			run(10);
			chk(hi, c <= 4);
			run(TO);
			run(10);
			chk(hi, 0);
		end
		give_verdict;
	end
	lwn_wake_notify #(.PWR_TIMEOUT_CYC(TO)) uut (.clock(clock), .sys_rst(sys_rst),
		.linkStatus(ls), .irqBits(irq), .linkOnPacket(pkt), .busReset(busRst),
		.powerCycled(pwrCyc), .powerClass(pwrClass), .wakeNotifyIn(wIn), .pState(pst),
		.pmeStsClear(clr), .linkRequestIn(rq), .phyStatusIn(ps), .wakeNotifyOut(wOut),
		.wakeNotifyOe(wOe), .pmEventStatus(pme), .linkRequestOut(rqOut),
		.phySerialStatus(psOut));
	lwn_link_model link (.clock(clock), .wakeOut(wOut), .wakeOe(wOe), .mode(mode),
		.linkStatus(ls), .pState(pst), .wakeIn(wIn));
endmodule
`default_nettype wire
